/* ssh_host_model.sv */
// wishbone host model standing in for the task file master
`timescale 1ns/100ps
module ssh_host_model (
   input wire logic clk_i,
   input wire logic ack_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   // idle bus at time zero
   initial
   begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // one classic cycle to whichever register offset the caller names, no drive/head
   // released lines show the inverse so a stale value never looks valid
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      begin
         @(posedge clk_i);
         cyc_o <= 1'b1;
         stb_o <= 1'b1;
         we_o <= we;
         adr_o <= adr;
         sel_o <= 4'hF;
         dat_o <= dat;
         do @(posedge clk_i); while (ack_i !== 1'b1);
         cyc_o <= 1'b0;
         stb_o <= 1'b0;
         we_o <= ~we;
         adr_o <= ~adr;
         sel_o <= 4'h0;
         dat_o <= ~dat;
      end
   endtask
endmodule

/* ssh_pkg.sv */
// package: register map, opcodes, reset values and carrier types of the security command handler
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package ssh_pkg;
   // ---------------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------------
   localparam logic [7:0] ADR_CMD = 8'h00;
   localparam logic [7:0] ADR_DATA = 8'h04;
   localparam logic [7:0] ADR_STAT = 8'h08;
   localparam logic [7:0] ADR_ERR = 8'h0C;
   localparam logic [7:0] ADR_SCNT = 8'h10;
   localparam logic [7:0] ADR_CTRL = 8'h14;
   localparam logic [7:0] ADR_KEY = 8'h18;
   localparam logic [7:0] ADR_IST = 8'h1C;
   localparam logic [7:0] ADR_ICLR = 8'h20;
   localparam logic [7:0] ADR_IEN = 8'h24;
   // ---------------------------------------------------------------------
   // opcodes, field positions, reset values
   // ---------------------------------------------------------------------
   localparam logic [7:0] OP_DISABLE = 8'hF6;
   localparam logic [7:0] OP_PREPARE = 8'hF3;
   localparam logic [7:0] OP_ERASE = 8'hF4;
   localparam logic [7:0] OP_FREEZE = 8'hF5;
   localparam int CTRL_LOCK_BIT = 0;
   localparam int CTRL_SEC_BIT = 1;
   localparam int KEY_MAS_BIT = 20;
   localparam int KEY_IDX_LSB = 16;
   localparam int ERR_ABRT_BIT = 2;
   localparam int SECTOR_WORDS_DEF = 256;
   localparam int PW_WORDS_DEF = 16;
   localparam int ATTEMPTS_DEF = 5;
   localparam logic [7:0] SCNT_RST = 8'h01;
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic SEC_RST = 1'b1;
   localparam logic [2:0] IRQ_RST = 3'h0;
   localparam int EV_DONE = 0;
   localparam int EV_ABRT = 1;
   localparam int EV_ERASE = 2;
   // ---------------------------------------------------------------------
   // carrier types
   // ---------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_XFER, ST_EXEC} ssh_state_t;
   typedef struct packed {
      logic vld;
      logic [7:0] idx;
      logic [15:0] data;
   } ssh_word_t;
   typedef struct packed {
      logic wr;
      logic master;
      logic [3:0] idx;
      logic [15:0] data;
   } ssh_key_t;
   typedef struct packed {
      logic [2:0] attempts;
      logic sec;
      logic prep;
      logic frozen;
      logic locked;
      logic bsy;
      logic drq;
      logic err;
   } ssh_stat_t;
endpackage

/* ssh_pw_cmp.sv */
// password store and streaming comparator for the security command handler
`timescale 1ns/100ps
module ssh_pw_cmp #(
   parameter int PW_WORDS = ssh_pkg::PW_WORDS_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ssh_pkg::ssh_key_t key_i,
   input wire ssh_pkg::ssh_word_t word_i,
   output logic match_o
);
   localparam int IW = $clog2(PW_WORDS);
   localparam logic [7:0] PW_LAST = 8'(PW_WORDS);

   logic [15:0] store_reg [2][PW_WORDS];
   logic mas_reg;
   logic mism_reg;

   if (PW_WORDS < 2 || PW_WORDS > 16)
   begin : g_chk
      $error("PW_WORDS must lie in 2..16");
   end

   // ---------------------------------------------------------------------
   // stored passwords, written only by software, never by a command
   // ---------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < PW_WORDS; i++)
         begin
            store_reg[0][i] <= 16'h0000;
            store_reg[1][i] <= 16'h0000;
         end
      end
      else if (key_i.wr && {1'b0, key_i.idx} < 5'(PW_WORDS))
      begin
         store_reg[key_i.master][key_i.idx[IW-1:0]] <= key_i.data;
      end
   end

   // word zero picks the set; words 1 to PW_WORDS are checked as they stream in, later ones are ignored
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mas_reg <= 1'b0;
         mism_reg <= 1'b0;
      end
      else if (word_i.vld)
      begin
         if (word_i.idx == 8'h00)
         begin
            mas_reg <= word_i.data[0];
            mism_reg <= 1'b0;
         end
         else if (word_i.idx <= PW_LAST && word_i.data !=
                  store_reg[mas_reg][IW'(word_i.idx - 8'h01)])
         begin
            mism_reg <= 1'b1;
         end
      end
   end

   assign match_o = ~mism_reg;

   // commands stream words but cannot touch the master set
   keep_master_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !key_i.wr |=> store_reg[1][0] == $past(store_reg[1][0]))
      else $error("master password changed without a key write");
endmodule

/* ssh_top.sv */
// security command handler: wishbone task file, sector intake, lock and freeze state
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
module ssh_top #(
   parameter int SECTOR_WORDS = ssh_pkg::SECTOR_WORDS_DEF,
   parameter int PW_WORDS = ssh_pkg::PW_WORDS_DEF,
   parameter int ATTEMPTS = ssh_pkg::ATTEMPTS_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   output logic erase_o,
   output logic wear_level_o
);
   localparam logic [7:0] LAST_WORD = 8'(SECTOR_WORDS - 1);
   localparam logic [2:0] ATT_INIT = 3'(ATTEMPTS);

   if (SECTOR_WORDS < PW_WORDS + 1 || SECTOR_WORDS > 256 || ATTEMPTS < 1 || ATTEMPTS > 7)
   begin : g_chk
      $error("sector, password or attempt size out of range");
   end

   ssh_pkg::ssh_state_t st_reg;
   ssh_pkg::ssh_state_t st_next;
   ssh_pkg::ssh_word_t word;
   ssh_pkg::ssh_key_t key;
   ssh_pkg::ssh_stat_t stat;
   logic ack_reg;
   logic [31:0] rdat_reg;
   logic [31:0] rmux;
   logic acc_wr;
   logic [7:0] cmd_reg;
   logic [7:0] scnt_reg;
   logic [7:0] widx_reg;
   logic err_reg;
   logic locked_reg;
   logic frozen_reg;
   logic prep_reg;
   logic sec_reg;
   logic [2:0] att_reg;
   logic [2:0] ist_reg;
   logic [2:0] ien_reg;
   logic erase_reg;
   logic wear_reg;
   logic match;
   logic cmd_go;
   logic fin;
   logic fin_err;
   logic unlock_ok;
   logic erase_ok;
   logic att_dec;

   // true when an accepted write hits the given offset
   function automatic logic wr_hit(input logic [7:0] a);
      return acc_wr && wb_adr_i == a;
   endfunction

   // ---------------------------------------------------------------------
   // wishbone slave: ack one cycle after the request, read data registered
   // ---------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
         rdat_reg <= rmux;
      end
   end

   // writes land on the edge that carries ack; lane 0 must be enabled
   assign acc_wr = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   // status view: unmapped and write-only offsets read as zero
   always_comb
   begin
      stat = '{attempts: att_reg, sec: sec_reg, prep: prep_reg, frozen: frozen_reg,
               locked: locked_reg, bsy: st_reg != ssh_pkg::ST_IDLE,
               drq: st_reg == ssh_pkg::ST_XFER, err: err_reg};
      unique case (wb_adr_i)
         ssh_pkg::ADR_CMD: rmux = {24'h00_0000, cmd_reg};
         ssh_pkg::ADR_STAT: rmux = {22'h00_0000, stat};
         ssh_pkg::ADR_ERR: rmux = {29'h0000_0000, err_reg, 2'h0};
         ssh_pkg::ADR_SCNT: rmux = {24'h00_0000, scnt_reg};
         ssh_pkg::ADR_CTRL: rmux = {30'h0000_0000, sec_reg, locked_reg};
         ssh_pkg::ADR_IST: rmux = {29'h0000_0000, ist_reg};
         ssh_pkg::ADR_IEN: rmux = {29'h0000_0000, ien_reg};
         default: rmux = 32'h0000_0000;
      endcase
   end

   // ---------------------------------------------------------------------
   // command intake and sector stream
   // ---------------------------------------------------------------------
   // a command written while busy is dropped, as on a real task file
   always_comb
   begin
      cmd_go = wr_hit(ssh_pkg::ADR_CMD) && st_reg == ssh_pkg::ST_IDLE;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cmd_reg <= ssh_pkg::CMD_RST;
      end
      else if (cmd_go)
      begin
         cmd_reg <= wb_dat_i[7:0];
      end
   end

   // word counter over the single data sector
   always_ff @(posedge clk_i)
   begin
      if (rst_i || st_reg != ssh_pkg::ST_XFER)
      begin
         widx_reg <= 8'h00;
      end
      else if (word.vld)
      begin
         widx_reg <= widx_reg + 8'h01;
      end
   end

   // a process, not assigns: wr_hit reads the bus inside, which an assign would not wake on
   always_comb
   begin
      word = '{vld: wr_hit(ssh_pkg::ADR_DATA) && st_reg == ssh_pkg::ST_XFER,
               idx: widx_reg, data: wb_dat_i[15:0]};
      key = '{wr: wr_hit(ssh_pkg::ADR_KEY), master: wb_dat_i[ssh_pkg::KEY_MAS_BIT],
              idx: wb_dat_i[ssh_pkg::KEY_IDX_LSB +: 4], data: wb_dat_i[15:0]};
   end

   ssh_pw_cmp #(
      .PW_WORDS(PW_WORDS)
   ) u_cmp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .key_i(key),
      .word_i(word),
      .match_o(match)
   );

   // ---------------------------------------------------------------------
   // command sequencer
   // ---------------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      fin = 1'b0;
      fin_err = 1'b0;
      unique case (st_reg)
         ssh_pkg::ST_IDLE:
         begin
            if (cmd_go)
            begin
               st_next = ssh_pkg::ST_CHECK;
            end
         end
         ssh_pkg::ST_CHECK:
         begin
            st_next = ssh_pkg::ST_IDLE;
            fin = 1'b1;
            unique case (cmd_reg)
               ssh_pkg::OP_DISABLE:
               begin
                  if (!sec_reg || frozen_reg)
                  begin
                     fin_err = 1'b1;
                  end
                  else
                  begin
                     fin = 1'b0;
                     st_next = ssh_pkg::ST_XFER;
                  end
               end
               ssh_pkg::OP_ERASE:
               begin
                  // no data is taken once any abort cause is known
                  if (!sec_reg || frozen_reg || !prep_reg || att_reg == 3'h0)
                  begin
                     fin_err = 1'b1;
                  end
                  else
                  begin
                     fin = 1'b0;
                     st_next = ssh_pkg::ST_XFER;
                  end
               end
               ssh_pkg::OP_PREPARE:
               begin
                  fin_err = !sec_reg;
               end
               default:
               begin
                  fin_err = 1'b0; // freeze and foreign opcodes just complete
               end
            endcase
         end
         ssh_pkg::ST_XFER:
         begin
            if (word.vld && widx_reg == LAST_WORD)
            begin
               st_next = ssh_pkg::ST_EXEC;
            end
         end
         ssh_pkg::ST_EXEC:
         begin
            st_next = ssh_pkg::ST_IDLE;
            fin = 1'b1;
            fin_err = !match;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg <= ssh_pkg::ST_IDLE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign unlock_ok = st_reg == ssh_pkg::ST_EXEC && match;
   assign erase_ok = unlock_ok && cmd_reg == ssh_pkg::OP_ERASE;
   assign att_dec = st_reg == ssh_pkg::ST_EXEC && !match && cmd_reg == ssh_pkg::OP_ERASE;

   // ---------------------------------------------------------------------
   // security state
   // ---------------------------------------------------------------------
   // lock mode: software restores it from media, a good password clears it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         locked_reg <= 1'b0;
      end
      else if (unlock_ok)
      begin
         locked_reg <= 1'b0;
      end
      else if (wr_hit(ssh_pkg::ADR_CTRL))
      begin
         locked_reg <= wb_dat_i[ssh_pkg::CTRL_LOCK_BIT];
      end
   end

   // feature-set present flag, steers freeze opcode decoding
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sec_reg <= ssh_pkg::SEC_RST;
      end
      else if (wr_hit(ssh_pkg::ADR_CTRL))
      begin
         sec_reg <= wb_dat_i[ssh_pkg::CTRL_SEC_BIT];
      end
   end

   // frozen: set by freeze, cleared by nothing but reset
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         frozen_reg <= 1'b0;
      end
      else if (fin && cmd_reg == ssh_pkg::OP_FREEZE && sec_reg)
      begin
         frozen_reg <= 1'b1;
      end
   end

   // prepare is armed only by the command just completed
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prep_reg <= 1'b0;
      end
      else if (fin)
      begin
         prep_reg <= cmd_reg == ssh_pkg::OP_PREPARE && !fin_err;
      end
   end

   // attempt counter; stays at zero until reset
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         att_reg <= ATT_INIT;
      end
      else if (att_dec && att_reg != 3'h0)
      begin
         att_reg <= att_reg - 3'h1;
      end
   end

   // error register and sector count as seen by the host
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         err_reg <= 1'b0;
         scnt_reg <= ssh_pkg::SCNT_RST;
      end
      else
      begin
         if (cmd_go)
         begin
            err_reg <= 1'b0;
         end
         else if (fin)
         begin
            err_reg <= fin_err;
         end
         if (fin && cmd_reg == ssh_pkg::OP_FREEZE && sec_reg)
         begin
            scnt_reg <= 8'h00;
         end
         else if (wr_hit(ssh_pkg::ADR_SCNT))
         begin
            scnt_reg <= wb_dat_i[7:0];
         end
      end
   end

   // one-cycle requests to the flash back end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         erase_reg <= 1'b0;
         wear_reg <= 1'b0;
      end
      else
      begin
         erase_reg <= erase_ok;
         wear_reg <= fin && cmd_reg == ssh_pkg::OP_FREEZE && !sec_reg;
      end
   end

   assign erase_o = erase_reg;
   assign wear_level_o = wear_reg;

   // ---------------------------------------------------------------------
   // interrupt status, enable and clear
   // ---------------------------------------------------------------------
   // a new event beats a clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ist_reg <= ssh_pkg::IRQ_RST;
         ien_reg <= ssh_pkg::IRQ_RST;
      end
      else
      begin
         ist_reg[ssh_pkg::EV_DONE] <= fin || (ist_reg[ssh_pkg::EV_DONE] &&
            !(wr_hit(ssh_pkg::ADR_ICLR) && wb_dat_i[ssh_pkg::EV_DONE]));
         ist_reg[ssh_pkg::EV_ABRT] <= (fin && fin_err) || (ist_reg[ssh_pkg::EV_ABRT] &&
            !(wr_hit(ssh_pkg::ADR_ICLR) && wb_dat_i[ssh_pkg::EV_ABRT]));
         ist_reg[ssh_pkg::EV_ERASE] <= erase_ok || (ist_reg[ssh_pkg::EV_ERASE] &&
            !(wr_hit(ssh_pkg::ADR_ICLR) && wb_dat_i[ssh_pkg::EV_ERASE]));
         if (wr_hit(ssh_pkg::ADR_IEN))
         begin
            ien_reg <= wb_dat_i[2:0];
         end
      end
   end

   assign irq_o = |(ist_reg & ien_reg);

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sector_length_a: assert property (
      st_reg == ssh_pkg::ST_XFER && word.vld && widx_reg == LAST_WORD |=>
      st_reg == ssh_pkg::ST_EXEC ##1 st_reg == ssh_pkg::ST_IDLE)
      else $error("sector did not close after its last word");
   unlock_clears_a: assert property (
      unlock_ok |=> !locked_reg)
      else $error("lock mode kept after a matching password");
   erase_pulse_a: assert property (
      erase_ok |=> erase_o ##1 !erase_o)
      else $error("erase request not a single pulse");
   erase_mismatch_a: assert property (
      att_dec |-> fin && fin_err ##1 err_reg)
      else $error("mismatching erase not aborted");
   erase_unprepared_a: assert property (
      st_reg == ssh_pkg::ST_CHECK && cmd_reg == ssh_pkg::OP_ERASE && !prep_reg |=>
      st_reg == ssh_pkg::ST_IDLE && err_reg)
      else $error("erase accepted without prepare");
   freeze_sets_a: assert property (
      fin && cmd_reg == ssh_pkg::OP_FREEZE && sec_reg |=> frozen_reg && scnt_reg == 8'h00)
      else $error("freeze did not freeze or zero sector count");
   frozen_reject_a: assert property (
      st_reg == ssh_pkg::ST_CHECK && frozen_reg && cmd_reg == ssh_pkg::OP_DISABLE |->
      fin_err ##1 !stat.drq)
      else $error("lock change accepted while frozen");
   frozen_holds_a: assert property (
      frozen_reg |=> frozen_reg)
      else $error("frozen state left without reset");
   wear_alias_a: assert property (
      fin && cmd_reg == ssh_pkg::OP_FREEZE && !sec_reg |=> wear_level_o && $stable(frozen_reg))
      else $error("freeze opcode not routed to wear level");
   attempts_out_a: assert property (
      st_reg == ssh_pkg::ST_CHECK && cmd_reg == ssh_pkg::OP_ERASE && att_reg == 3'h0 |->
      fin_err)
      else $error("erase taken with no attempts left");
   abort_report_a: assert property (
      fin && fin_err |=> err_reg && ist_reg[ssh_pkg::EV_ABRT] && ist_reg[ssh_pkg::EV_DONE])
      else $error("abort not reported");

   erase_done_c: cover property (erase_ok);
   disable_done_c: cover property (unlock_ok && cmd_reg == ssh_pkg::OP_DISABLE);
   freeze_twice_c: cover property (frozen_reg && fin && cmd_reg == ssh_pkg::OP_FREEZE);
   attempts_zero_c: cover property (att_reg == 3'h0);
endmodule

/* ssh_top_tb.sv */
// self-checking testbench of the security command handler
`timescale 1ns/100ps
module ssh_top_tb;
   localparam int SW = 32;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, irq_o, erase_o, wear_level_o;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   logic [31:0] exp_q[$];
   logic [15:0] upw[16];
   logic [15:0] mpw[16];
   integer seed = 32'ha773ade8;
   int miscompares = 0;
   int total_checks = 0;
   int n_erase = 0;
   int n_wear = 0;
   // clock of 50 ns
   initial
   begin
      forever #25 clk_i = ~clk_i;
   end
   ssh_top #(.SECTOR_WORDS(SW)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq_o), .erase_o(erase_o),
      .wear_level_o(wear_level_o));
   ssh_host_model i_host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   // ---------------------------------------------------------------
   // checking
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
      begin
         total_checks++;
         if (g !== e)
         begin
            $display("ERROR %s expected %h seen %h", name, e, g);
            miscompares++;
         end
      end
   endtask
   task automatic finish_test;
      begin
         $display("checks %0d mismatches %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // read data is compared against the oldest note; pulses are counted
   always @(posedge clk_i)
   begin
      if (ack === 1'b1 && we === 1'b0)
         check("rdata", exp_q.pop_front(), rdat);
      if (erase_o === 1'b1)
         n_erase++;
      if (wear_level_o === 1'b1)
         n_wear++;
   end
   // cut a hang short well past the expected run length
   initial
   begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      finish_test();
   end
   // ---------------------------------------------------------------
   // bus and command tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      begin
         exp_q.push_back(e);
         i_host.xfer(1'b0, a, 32'h0);
      end
   endtask
   task automatic reset;
      begin
         rst_i <= 1'b1;
         repeat (12) @(posedge clk_i);
         rst_i <= 1'b0;
      end
   endtask
   // status word: attempts, security present, frozen, locked, error
   function automatic logic [31:0] st(input int a, input logic s, f, l, e);
      return {22'h0, a[2:0], s, 1'b0, f, l, 2'b00, e};
   endfunction
   // opcode plus slack for the single check cycle
   task automatic cmd(input logic [7:0] op);
      begin
         wr(ssh_pkg::ADR_CMD, {24'h0, op});
         repeat (3) @(posedge clk_i);
      end
   endtask
   // whole sector; a bad password differs only in its last bit, the hardest spot
   task automatic sector(input logic [7:0] op, input logic m, input logic good);
      logic [15:0] w;
      begin
         cmd(op);
         w = 16'($random(seed));
         w[0] = m;
         wr(ssh_pkg::ADR_DATA, {16'h0, w});
         for (int i = 1; i < SW; i++)
         begin
            w = 16'($random(seed));
            if (i <= 16)
               w = (m ? mpw[i-1] : upw[i-1]) ^ {15'h0, (i == 16 && !good)};
            wr(ssh_pkg::ADR_DATA, {16'h0, w});
         end
         repeat (3) @(posedge clk_i);
      end
   endtask
   // main sequence
   initial
   begin
      reset();
      rd(ssh_pkg::ADR_SCNT, 32'h1);
      rd(ssh_pkg::ADR_CTRL, 32'h2);
      rd(ssh_pkg::ADR_STAT, st(5, 1, 0, 0, 0));
      rd(ssh_pkg::ADR_IEN, 32'h0);
      rd(8'h30, 32'h0);
      for (int i = 0; i < 16; i++)
      begin
         upw[i] = 16'($random(seed));
         mpw[i] = 16'($random(seed));
         wr(ssh_pkg::ADR_KEY, {11'h0, 1'b0, i[3:0], upw[i]});
         wr(ssh_pkg::ADR_KEY, {11'h0, 1'b1, i[3:0], mpw[i]});
      end
      wr(ssh_pkg::ADR_IEN, 32'h2);
      wr(ssh_pkg::ADR_CTRL, 32'h3);
      sector(ssh_pkg::OP_DISABLE, 1'b0, 1'b0);
      rd(ssh_pkg::ADR_ERR, 32'h4);
      rd(ssh_pkg::ADR_STAT, st(5, 1, 0, 1, 1));
      check("irq", 32'h1, {31'h0, irq_o});
      wr(ssh_pkg::ADR_ICLR, 32'h7);
      @(posedge clk_i); // the clear lands on the ack edge; look once it has settled
      check("irq", 32'h0, {31'h0, irq_o});
      sector(ssh_pkg::OP_DISABLE, 1'b0, 1'b1);
      rd(ssh_pkg::ADR_STAT, st(5, 1, 0, 0, 0));
      check("irq", 32'h0, {31'h0, irq_o});
      wr(ssh_pkg::ADR_CTRL, 32'h3);
      sector(ssh_pkg::OP_DISABLE, 1'b1, 1'b1);
      rd(ssh_pkg::ADR_STAT, st(5, 1, 0, 0, 0));
      wr(ssh_pkg::ADR_CTRL, 32'h3);
      cmd(ssh_pkg::OP_ERASE);
      rd(ssh_pkg::ADR_STAT, st(5, 1, 0, 1, 1));
      cmd(ssh_pkg::OP_PREPARE);
      cmd(8'h40);
      cmd(ssh_pkg::OP_ERASE);
      rd(ssh_pkg::ADR_STAT, st(5, 1, 0, 1, 1));
      cmd(ssh_pkg::OP_PREPARE);
      sector(ssh_pkg::OP_ERASE, 1'b0, 1'b0);
      rd(ssh_pkg::ADR_STAT, st(4, 1, 0, 1, 1));
      cmd(ssh_pkg::OP_PREPARE);
      sector(ssh_pkg::OP_ERASE, 1'b0, 1'b1);
      check("erase", 32'h1, n_erase);
      rd(ssh_pkg::ADR_STAT, st(4, 1, 0, 0, 0));
      for (int k = 0; k < 4; k++)
      begin
         cmd(ssh_pkg::OP_PREPARE);
         sector(ssh_pkg::OP_ERASE, 1'b0, 1'b0);
      end
      cmd(ssh_pkg::OP_PREPARE);
      cmd(ssh_pkg::OP_ERASE);
      rd(ssh_pkg::ADR_STAT, st(0, 1, 0, 0, 1));
      check("erase", 32'h1, n_erase);
      reset();
      wr(ssh_pkg::ADR_SCNT, 32'h55);
      cmd(ssh_pkg::OP_FREEZE);
      rd(ssh_pkg::ADR_SCNT, 32'h0);
      rd(ssh_pkg::ADR_STAT, st(5, 1, 1, 0, 0));
      cmd(ssh_pkg::OP_DISABLE);
      rd(ssh_pkg::ADR_ERR, 32'h4);
      cmd(ssh_pkg::OP_PREPARE);
      cmd(ssh_pkg::OP_ERASE);
      rd(ssh_pkg::ADR_STAT, st(5, 1, 1, 0, 1));
      cmd(ssh_pkg::OP_FREEZE);
      rd(ssh_pkg::ADR_STAT, st(5, 1, 1, 0, 0));
      reset();
      rd(ssh_pkg::ADR_STAT, st(5, 1, 0, 0, 0));
      wr(ssh_pkg::ADR_CTRL, 32'h0);
      wr(ssh_pkg::ADR_SCNT, 32'h55);
      cmd(ssh_pkg::OP_FREEZE);
      check("wear", 32'h1, n_wear);
      rd(ssh_pkg::ADR_STAT, st(5, 0, 0, 0, 0));
      rd(ssh_pkg::ADR_SCNT, 32'h55);
      finish_test();
   end
endmodule
